// file: logic/smi_defs.svh
`ifndef SMI_DEFS_SVH
`define SMI_DEFS_SVH

// Position counter: one electrical cycle at the finest resolution
`define SMI_POS_W        10
`define SMI_POS_HOME     10'h080
`define SMI_FULL_OFS     10'h080
`define SMI_QUARTER      9'h100
`define SMI_POS_ONE      10'h001

// Step resolution codes
`define SMI_MODE_FULL100 4'h0
`define SMI_MODE_FULL71  4'h1
`define SMI_MODE_NCHALF  4'h2
`define SMI_MODE_HALF    4'h3
`define SMI_MODE_QUARTER 4'h4
`define SMI_MODE_EIGHTH  4'h5
`define SMI_MODE_16      4'h6
`define SMI_MODE_32      4'h7
`define SMI_MODE_64      4'h8
`define SMI_MODE_128     4'h9
`define SMI_MODE_256     4'hA

// Position increments per step, in finest states
`define SMI_INC_FULL     10'h100
`define SMI_INC_HALF     10'h080
`define SMI_INC_QUARTER  10'h040
`define SMI_INC_EIGHTH   10'h020
`define SMI_INC_16       10'h010
`define SMI_INC_32       10'h008
`define SMI_INC_64       10'h004
`define SMI_INC_128      10'h002
`define SMI_INC_256      10'h001

// Targets in percent of full scale
`define SMI_PCT_W        8
`define SMI_PCT_FULL     8'h64
`define SMI_PCT_71       8'h47
`define SMI_PCT_ZERO     8'h00

// Coarse sine table: entries per quarter, fine states per entry
`define SMI_TBL_LAST     6'h20
`define SMI_TBL_SHIFT    3

`endif

// file: logic/smi_pkg.sv
package smi_pkg;

  typedef enum logic [3:0] {
    SMI_FULL100 = 4'h0,
    SMI_FULL71  = 4'h1,
    SMI_NCHALF  = 4'h2,
    SMI_HALF    = 4'h3,
    SMI_QUARTER = 4'h4,
    SMI_EIGHTH  = 4'h5,
    SMI_S16     = 4'h6,
    SMI_S32     = 4'h7,
    SMI_S64     = 4'h8,
    SMI_S128    = 4'h9,
    SMI_S256    = 4'hA
  } smi_mode_t;

  typedef struct packed {
    logic [9:0]        pos;
    logic              step_d;
    logic [3:0]        mode_prev;
    logic              hold_once;
    logic signed [7:0] tgt_a;
    logic signed [7:0] tgt_b;
  } smi_state_t;

endpackage

// file: logic/smi_tgt_if.sv
`timescale 1ns/1ps
interface smi_tgt_if;
  logic [9:0]        angle;
  logic signed [7:0] sin_pct;
  logic signed [7:0] cos_pct;

  modport indexer (
    output angle,
    input  sin_pct,
    input  cos_pct
  );

  modport table_side (
    input  angle,
    output sin_pct,
    output cos_pct
  );
endinterface

// file: logic/smi_sine_rom.sv
`timescale 1ns/1ps
`include "smi_defs.svh"

module smi_sine_rom (
  smi_tgt_if.table_side tgt
);

  ////////////////////////////////////////////////////////////////////////
  // Coarse quarter wave, fine states between entries interpolated
  // [R12] Exact on every eighth-step point
  function automatic logic [7:0] smi_coarse(input logic [5:0] k);
    case (k)
      6'h00: smi_coarse = 8'h00;  6'h01: smi_coarse = 8'h05;
      6'h02: smi_coarse = 8'h0A;  6'h03: smi_coarse = 8'h0F;
      6'h04: smi_coarse = 8'h14;  6'h05: smi_coarse = 8'h18;
      6'h06: smi_coarse = 8'h1D;  6'h07: smi_coarse = 8'h22;
      6'h08: smi_coarse = 8'h26;  6'h09: smi_coarse = 8'h2B;
      6'h0A: smi_coarse = 8'h2F;  6'h0B: smi_coarse = 8'h33;
      6'h0C: smi_coarse = 8'h38;  6'h0D: smi_coarse = 8'h3C;
      6'h0E: smi_coarse = 8'h3F;  6'h0F: smi_coarse = 8'h43;
      6'h10: smi_coarse = 8'h47;  6'h11: smi_coarse = 8'h4A;
      6'h12: smi_coarse = 8'h4D;  6'h13: smi_coarse = 8'h50;
      6'h14: smi_coarse = 8'h53;  6'h15: smi_coarse = 8'h56;
      6'h16: smi_coarse = 8'h58;  6'h17: smi_coarse = 8'h5A;
      6'h18: smi_coarse = 8'h5C;  6'h19: smi_coarse = 8'h5E;
      6'h1A: smi_coarse = 8'h60;  6'h1B: smi_coarse = 8'h61;
      6'h1C: smi_coarse = 8'h62;  6'h1D: smi_coarse = 8'h63;
      default: smi_coarse = 8'h64;
    endcase
  endfunction

  // Magnitude for a fine index 0..256 within a quarter
  function automatic logic [7:0] smi_quarter(input logic [8:0] idx);
    logic [5:0] k;
    logic [2:0] f;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [10:0] step;
    k    = idx[8:3];
    f    = idx[2:0];
    lo   = smi_coarse(k);
    hi   = (k == `SMI_TBL_LAST) ? lo : smi_coarse(k + 6'h01);
    step = 11'((hi - lo) * f) + 11'h004;
    smi_quarter = lo + 8'(step >> `SMI_TBL_SHIFT);
  endfunction

  // Sign from quadrant, mirrored index in quadrants 1 and 3
  function automatic logic signed [7:0] smi_sine(input logic [9:0] a);
    logic [8:0] idx;
    logic [7:0] mag;
    idx = a[8] ? (`SMI_QUARTER - {1'b0, a[7:0]}) : {1'b0, a[7:0]};
    mag = smi_quarter(idx);
    smi_sine = a[9] ? -$signed(mag) : $signed(mag);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // [R18] Shared quarter table
  assign tgt.sin_pct = smi_sine(tgt.angle);
  // Quarter turn ahead gives cosine; wraps within one cycle
  assign tgt.cos_pct = smi_sine(10'(tgt.angle + `SMI_FULL_OFS
                                    + `SMI_FULL_OFS));

endmodule

// file: logic/smi_indexer.sv
// Contract
// [R1] Separate current targets for winding A and winding B.
// [R2] Code 0 full step at 100%, code 1 full step at 71%.
// [R3] Code 2 noncircular half step, code 3 circular half step.
// [R4] Codes 4..10 select quarter through 1/256 microstepping.
// [R5] Winding A target is sine, winding B cosine, in signed percent.
// [R6] Positive target means current from first to second terminal.
// [R7] Each step rising edge advances exactly one state of the mode.
// [R8] Direction high raises angle, low reverses; set before step edge.
// [R9] After a resolution change, next edge goes to next valid state.
// [R10] Reverse, full angle, micro to full change: first edge holds.
// [R11] Home is 45 degrees after reset, undervoltage exit, sleep exit.
// [R12] Eighth step has 32 states; 0/100, 71/71, 100/0 examples.
// [R13] Quarter and half visit subsets; 71% full step uses diagonals.
// [R14] Finer modes follow the same sine pattern, evenly spaced.
// [R15] Full step 100% uses diagonals with targets of plus/minus 100.
// [R16] Noncircular half uses 45 degree states with 0 or 100 targets.
// [R17] Position wraps modulo one cycle; 1024 states at 1/256.
// [R18] Targets come from one quarter table, sign from quadrant.
`timescale 1ns/1ps
`include "smi_defs.svh"

module smi_indexer (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              step_in,
  input  wire logic              dir_in,
  input  wire logic [3:0]        step_mode,
  input  wire logic              sleep_req,
  input  wire logic              uvlo_active,
  output logic signed [7:0]      winding_a_output,
  output logic signed [7:0]      winding_b_output,
  output logic [9:0]             electrical_position
);

  ////////////////////////////////////////////////////////////////////////
  // Mode decoding

  // [R14] Evenly spaced steps
  function automatic logic [9:0] smi_inc(input logic [3:0] m);
    case (m)
      `SMI_MODE_FULL100, `SMI_MODE_FULL71: smi_inc = `SMI_INC_FULL;
      `SMI_MODE_NCHALF, `SMI_MODE_HALF:    smi_inc = `SMI_INC_HALF;
      `SMI_MODE_QUARTER:                   smi_inc = `SMI_INC_QUARTER;
      `SMI_MODE_EIGHTH:                    smi_inc = `SMI_INC_EIGHTH;
      `SMI_MODE_16:                        smi_inc = `SMI_INC_16;
      `SMI_MODE_32:                        smi_inc = `SMI_INC_32;
      `SMI_MODE_64:                        smi_inc = `SMI_INC_64;
      `SMI_MODE_128:                       smi_inc = `SMI_INC_128;
      default:                             smi_inc = `SMI_INC_256;
    endcase
  endfunction

  function automatic logic smi_is_full(input logic [3:0] m);
    smi_is_full = (m == `SMI_MODE_FULL100) || (m == `SMI_MODE_FULL71);
  endfunction

  function automatic logic [9:0] smi_offset(input logic [3:0] m);
    smi_offset = smi_is_full(m) ? `SMI_FULL_OFS : 10'h000;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  smi_pkg::smi_state_t st_reg;
  smi_pkg::smi_state_t st_next;
  smi_tgt_if           tgt ();

  logic [9:0] inc_w;
  logic [9:0] ofs_w;
  logic [9:0] rel_w;
  logic [9:0] mask_w;
  logic       aligned_w;
  logic       step_rise;
  logic       go_home;
  logic       hold_edge;

  smi_sine_rom u_rom (
    .tgt (tgt.table_side)
  );

  assign inc_w     = smi_inc(step_mode);
  assign ofs_w     = smi_offset(step_mode);
  assign mask_w    = inc_w - `SMI_POS_ONE;
  assign rel_w     = st_reg.pos - ofs_w;
  assign aligned_w = (rel_w & mask_w) == 10'h000;
  assign step_rise = step_in && !st_reg.step_d;
  // Sleep and undervoltage keep the indexer parked at home
  assign go_home   = sleep_req || uvlo_active;
  // [R10] Held edge
  assign hold_edge = st_reg.hold_once && !dir_in && aligned_w
                     && smi_is_full(step_mode);

  assign tgt.angle = st_reg.pos;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next        = st_reg;
    st_next.step_d = step_in;
    st_next.mode_prev = step_mode;
    // [R10] Arm on micro to full
    if (smi_is_full(step_mode) && !smi_is_full(st_reg.mode_prev)) begin
      st_next.hold_once = 1'b1;
    end else if (!smi_is_full(step_mode)) begin
      st_next.hold_once = 1'b0;
    end
    if (go_home) begin
      // [R11] Home on sleep or undervoltage
      st_next.pos       = `SMI_POS_HOME;
      st_next.hold_once = 1'b0;
    end else if (step_rise) begin
      st_next.hold_once = 1'b0;
      if (hold_edge) begin
        st_next.pos = st_reg.pos;
      end else if (dir_in) begin
        // [R8] Forward direction
        // [R9] Realign to new mode
        // [R17] Natural wrap
        st_next.pos = ofs_w + (rel_w & ~mask_w) + inc_w;
      end else if (!aligned_w) begin
        // [R9] Realign downward
        st_next.pos = ofs_w + (rel_w & ~mask_w);
      end else begin
        // [R7] One state back
        st_next.pos = st_reg.pos - inc_w;
      end
    end
    // [R6] Sign carries polarity
    case (step_mode)
      `SMI_MODE_FULL100: begin
        // [R15] Full 100% targets
        st_next.tgt_a = tgt.sin_pct[7] ? -$signed(`SMI_PCT_FULL)
                                       : $signed(`SMI_PCT_FULL);
        st_next.tgt_b = tgt.cos_pct[7] ? -$signed(`SMI_PCT_FULL)
                                       : $signed(`SMI_PCT_FULL);
      end
      `SMI_MODE_FULL71: begin
        // [R13] Full 71% targets
        st_next.tgt_a = tgt.sin_pct[7] ? -$signed(`SMI_PCT_71)
                                       : $signed(`SMI_PCT_71);
        st_next.tgt_b = tgt.cos_pct[7] ? -$signed(`SMI_PCT_71)
                                       : $signed(`SMI_PCT_71);
      end
      `SMI_MODE_NCHALF: begin
        // [R16] Square targets
        st_next.tgt_a = tgt.sin_pct[7] ? -$signed(`SMI_PCT_FULL)
                      : (tgt.sin_pct == $signed(`SMI_PCT_ZERO))
                        ? $signed(`SMI_PCT_ZERO) : $signed(`SMI_PCT_FULL);
        st_next.tgt_b = tgt.cos_pct[7] ? -$signed(`SMI_PCT_FULL)
                      : (tgt.cos_pct == $signed(`SMI_PCT_ZERO))
                        ? $signed(`SMI_PCT_ZERO) : $signed(`SMI_PCT_FULL);
      end
      default: begin
        // [R5] Sine and cosine
        // [R2] [R3] [R4] Modes by code
        st_next.tgt_a = tgt.sin_pct;
        st_next.tgt_b = tgt.cos_pct;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      // [R11] Power-up home
      st_reg.pos       <= `SMI_POS_HOME;
      st_reg.step_d    <= 1'b1;
      st_reg.mode_prev <= `SMI_MODE_FULL100;
      st_reg.hold_once <= 1'b0;
      st_reg.tgt_a     <= $signed(`SMI_PCT_71);
      st_reg.tgt_b     <= $signed(`SMI_PCT_71);
    end else begin
      st_reg <= st_next;
    end
  end

  // [R1] Two winding targets
  assign winding_a_output    = st_reg.tgt_a;
  assign winding_b_output    = st_reg.tgt_b;
  assign electrical_position = st_reg.pos;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [9:0] pos_delta;
  assign pos_delta = st_next.pos - st_reg.pos;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_rise_fwd;
    step_rise && dir_in && !go_home && !hold_edge;
  endsequence

  sequence s_rise_rev;
    step_rise && !dir_in && !go_home && !hold_edge && aligned_w;
  endsequence

  sequence s_arm_full;
    !smi_is_full(step_mode) ##1 smi_is_full(step_mode);
  endsequence

  a_fwd_one_step: assert property ( // [R7]
    s_rise_fwd |-> pos_delta != 10'h000 && pos_delta <= inc_w)
    else $error("forward step moved wrong distance");

  a_rev_one_step: assert property ( // [R8]
    s_rise_rev |=> st_reg.pos == 10'($past(st_reg.pos) - $past(inc_w)))
    else $error("reverse step moved wrong distance");

  a_no_edge_still: assert property ( // [R7]
    !step_rise && !go_home |=> $stable(st_reg.pos))
    else $error("position moved without a step edge");

  a_home_park: assert property ( // [R11]
    go_home |=> st_reg.pos == `SMI_POS_HOME)
    else $error("indexer not at home after sleep or undervoltage");

  a_rev_hold_once: assert property ( // [R10]
    st_reg.hold_once && smi_is_full(step_mode) && step_rise && !dir_in
      && aligned_w && !go_home |=> $stable(st_reg.pos))
    else $error("first reverse edge after full step change moved");

  a_hold_arm: assert property ( // [R10]
    s_arm_full ##0 (!go_home && !step_rise) |=> st_reg.hold_once)
    else $error("hold flag not armed on change to full step");

  // Full modes must land on diagonals only
  a_full_grid: assert property ( // [R15]
    step_rise && !go_home && smi_is_full(step_mode)
      |=> st_reg.pos[7:0] == 8'h80)
    else $error("full step left the diagonal angles");

  a_half_grid: assert property ( // [R13]
    step_rise && !go_home && step_mode == `SMI_MODE_HALF
      |=> st_reg.pos[6:0] == 7'h00)
    else $error("half step left the 45 degree grid");

  a_nchalf_set: assert property ( // [R16]
    step_mode == `SMI_MODE_NCHALF && $stable(step_mode)
      |=> st_reg.tgt_a == 8'sh00 || st_reg.tgt_a == 8'sh64
       || st_reg.tgt_a == -8'sh64)
    else $error("noncircular half target not 0 or 100");

  a_full100_mag: assert property ( // [R15]
    step_mode == `SMI_MODE_FULL100 && $stable(step_mode)
      |=> (st_reg.tgt_a == 8'sh64 || st_reg.tgt_a == -8'sh64)
       && (st_reg.tgt_b == 8'sh64 || st_reg.tgt_b == -8'sh64))
    else $error("full step target not plus or minus 100");

  a_full71_mag: assert property ( // [R13]
    step_mode == `SMI_MODE_FULL71
      |=> st_reg.tgt_a == 8'sh47 || st_reg.tgt_a == -8'sh47)
    else $error("71 percent full step magnitude wrong");

  a_home_target: assert property ( // [R12]
    step_mode == `SMI_MODE_EIGHTH && st_reg.pos == `SMI_POS_HOME
      |=> st_reg.tgt_a == 8'sh47 && st_reg.tgt_b == 8'sh47)
    else $error("45 degree target pair is not 71/71");

  a_axis_target: assert property ( // [R5]
    !smi_is_full(step_mode) && st_reg.pos == 10'h100
      |=> st_reg.tgt_a == 8'sh64 && st_reg.tgt_b == 8'sh00)
    else $error("90 degree target pair is not 100/0");

endmodule

// file: test/smi_step_ctl.sv
`timescale 1ns/1ps
module smi_step_ctl (
  input  wire logic clock,
  output logic      step_in,
  output logic      dir_in
);
  // Slow controller: longer high phase
  int unsigned high_cycles = 1;

  initial begin
    step_in = 1'b0;
    dir_in  = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction settles first
  // Held through the whole pulse, so it also meets hold time
  task automatic pulse(input logic dir);
    @(negedge clock);
    dir_in = dir;
    @(negedge clock);
    step_in = 1'b1;
    repeat (high_cycles) @(negedge clock);
    step_in = 1'b0;
    @(negedge clock);
  endtask
endmodule

// file: test/smi_indexer_tb_top.sv
`timescale 1ns/1ps
module smi_indexer_tb_top;
  logic              clock = 1'b0;
  logic              resetn;
  logic              step_in;
  logic              dir_in;
  logic [3:0]        step_mode;
  logic              sleep_req;
  logic              uvlo_active;
  logic signed [7:0] winding_a_output;
  logic signed [7:0] winding_b_output;
  logic [9:0]        electrical_position;
  logic [9:0]        exp_pos;
  int                num_errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  localparam logic [7:0] TBL [0:8] = '{8'h00, 8'h14, 8'h26, 8'h38, 8'h47,
                                       8'h53, 8'h5C, 8'h62, 8'h64};

  always #12.5 clock = ~clock;

  smi_step_ctl ctl (.clock(clock), .step_in(step_in), .dir_in(dir_in));

  smi_indexer dut (
    .clock               (clock),
    .resetn              (resetn),
    .step_in             (step_in),
    .dir_in              (dir_in),
    .step_mode           (step_mode),
    .sleep_req           (sleep_req),
    .uvlo_active         (uvlo_active),
    .winding_a_output    (winding_a_output),
    .winding_b_output    (winding_b_output),
    .electrical_position (electrical_position)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] inc_of(input logic [3:0] m);
    logic [10:0] t;
    t = 11'h400 >> m;
    if (m < 4'h2) return 10'h100;
    if (m == 4'h2) return 10'h080;
    return t[9:0];
  endfunction

  function automatic logic [9:0] next_pos(input logic [9:0] p,
                                          input logic [3:0] m,
                                          input logic d);
    logic [9:0] off;
    logic [9:0] inc;
    logic [9:0] rel;
    logic [9:0] al;
    off = (m < 4'h2) ? 10'h080 : 10'h000;
    inc = inc_of(m);
    rel = p - off;
    al = rel & ~(inc - 10'h001);
    if (d) return off + al + inc;
    return (rel != al) ? off + al : p - inc;
  endfunction

  // Valid only on eighth-step points
  function automatic logic signed [7:0] exp_sin(input logic [9:0] p,
                                                input logic [3:0] m);
    logic [3:0] r;
    logic [7:0] v;
    r = {1'b0, p[7:5]};
    if (p[8]) r = 4'h8 - r;
    v = TBL[r];
    if (m < 4'h3 && v != 8'h00) v = (m == 4'h1) ? 8'h47 : 8'h64;
    return p[9] ? -v : v;
  endfunction

  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_tgt();
    if (exp_pos[4:0] == 5'h00) begin
      check("winding_a", 10'(winding_a_output),
            10'(exp_sin(exp_pos, step_mode)));
      check("winding_b", 10'(winding_b_output),
            10'(exp_sin(exp_pos + 10'h100, step_mode)));
    end
  endtask

  task automatic step_chk(input logic d);
    ctl.pulse(d);
    exp_pos = next_pos(exp_pos, step_mode, d);
    check("position", electrical_position, exp_pos);
    check_tgt();
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(negedge clock);
    step_mode = m;
    repeat (2) @(negedge clock);
    check_tgt();
  endtask

  // Steps while parked must be ignored
  task automatic park(input logic use_uvlo);
    @(negedge clock);
    sleep_req = !use_uvlo;
    uvlo_active = use_uvlo;
    ctl.pulse(1'b1);
    check("parked position", electrical_position, 10'h080);
    sleep_req = 1'b0;
    uvlo_active = 1'b0;
    repeat (2) @(negedge clock);
    exp_pos = 10'h080;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    exp_pos = 10'h080;
    check("home position", electrical_position, 10'h080);
    check("home a", 10'(winding_a_output), 10'h047);
    check("home b", 10'(winding_b_output), 10'h047);
  endtask

  // Full electrical cycle, wraps, then back with a slow controller
  task automatic t_eighth_cycle();
    repeat (33) step_chk(1'b1);
    ctl.high_cycles = 3;
    repeat (3) step_chk(1'b0);
    ctl.high_cycles = 1;
  endtask

  task automatic t_all_modes();
    for (int m = 0; m < 11; m++) begin
      park(m[0]);
      set_mode(4'(m));
      repeat (5) step_chk(1'b1);
      repeat (5) step_chk(1'b0);
    end
  endtask

  task automatic t_mode_change();
    park(1'b0);
    set_mode(4'h5);
    step_chk(1'b1);
    set_mode(4'h3);
    step_chk(1'b1);
    set_mode(4'h6);
    step_chk(1'b0);
    set_mode(4'h2);
    step_chk(1'b0);
  endtask

  task automatic t_full_hold();
    park(1'b1);
    set_mode(4'h5);
    set_mode(4'h0);
    ctl.pulse(1'b0);
    check("held position", electrical_position, 10'h080);
    step_chk(1'b0);
    step_chk(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Run takes about 770 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    resetn = 1'b0;
    step_mode = 4'h5;
    sleep_req = 1'b0;
    uvlo_active = 1'b0;
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    t_reset();
    t_eighth_cycle();
    t_all_modes();
    t_mode_change();
    t_full_hold();
    final_report();
  end
endmodule
